// ### bench/ram_model.sv
/*
  Behavioural RAM array behind the controller: 64K words of 22 bits.
  Assumes registered strobes and word address on ref_clk.
*/
`timescale 1ns/1ps
module ram_model (
  input wire logic ref_clk,
  input wire logic cs,
  input wire logic we_data,
  input wire logic we_check,
  input wire logic [15:0] addr,
  input wire logic [21:0] wdata,
  output logic [21:0] rdata
);
  // ==========
  // Storage
  logic [21:0] mem [0:65535];
  logic [21:0] last_ff = 22'h000000;
  // Data and check halves have separate strobes so check bits can be kept
  always_ff @(posedge ref_clk) begin
    if (cs && we_data) mem[addr][15:0] <= wdata[15:0];
    if (cs && we_check) mem[addr][21:16] <= wdata[21:16];
    if (cs) last_ff <= mem[addr];
  end
  // Deselected: inverse of last word, so stale data never looks valid
  assign rdata = cs ? mem[addr] : ~last_ff;
endmodule : ram_model

// ### bench/tb_edac_memory_protect_ctrl.sv
/*
  Self-checking bench for the error-corrected memory controller.
  Assumes the RAM model on the far side and a 100 MHz ref_clk.
*/
`timescale 1ns/1ps
module tb_edac_memory_protect_ctrl;
  import edac_pkg::*;
  // ==========
  // Signals
  localparam int MC = 20;
  localparam logic [17:0] ALL = 18'h3ffff;
  localparam logic [23:0] W1 = 24'hfe0100;
  localparam logic [23:0] W2 = 24'hfe0200;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] req = 4'h0;
  logic [3:0] we = 4'h0;
  logic [3:0][AW-1:0] addr = '0;
  logic [3:0][15:0] wdata = '0;
  logic cpu_user = 1'b0;
  logic cb_wr_dis = 1'b0;
  logic master_clear = 1'b0;
  logic [21:0] ram_rdata;
  logic [15:0] rom_rdata = 16'h0000;
  logic [3:0] ack_ff;
  logic [17:0] rdata_ff;
  logic cpu_bus_err_ff, host_memory_error_ff, ram_cs_ff, ram_we_data_ff;
  logic ram_we_check_ff, single_err_irq_ff, mem_err_irq_ff, wp_viol_irq_ff;
  logic power_low_irq_ff, local_reset_ff;
  logic [15:0] ram_addr_ff;
  logic [21:0] ram_wdata_ff;
  logic [11:0] rom_addr_ff;
  int errors = 0, compares = 0, cyc = 0, seed = 15621;
  int se = 0, me = 0, wp = 0, hm = 0, k, n;
  logic [35:0] q[$];
  logic [35:0] t;
  logic [15:0] d, e;
  edac_memory_protect_ctrl #(.MCLR_CYC(MC)) edac_memory_protect_ctrl_i (
    .ref_clk, .sys_rst, .req, .we, .addr, .wdata, .cpu_user, .cb_wr_dis,
    .master_clear, .ram_rdata, .rom_rdata, .ack_ff, .rdata_ff,
    .cpu_bus_err_ff, .host_memory_error_ff, .ram_cs_ff, .ram_we_data_ff,
    .ram_we_check_ff, .ram_addr_ff, .ram_wdata_ff, .rom_addr_ff,
    .single_err_irq_ff, .mem_err_irq_ff, .wp_viol_irq_ff,
    .power_low_irq_ff, .local_reset_ff);
  ram_model ram_model_i (.ref_clk, .cs(ram_cs_ff), .we_data(ram_we_data_ff),
    .we_check(ram_we_check_ff), .addr(ram_addr_ff), .wdata(ram_wdata_ff),
    .rdata(ram_rdata));
  always #5 ref_clk = ~ref_clk;
  // ==========
  // Tasks
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic go(input int i, input logic w, input logic [23:0] a,
    input logic [15:0] dv, input logic [17:0] m, input logic [17:0] x);
    req[i] <= 1'b1;
    we[i] <= w;
    addr[i] <= a;
    wdata[i] <= dv;
    q.push_back({m, x});
  endtask : go
  // Waits for the answer; nx > 0 also checks its cycle count
  task automatic wack(input int i, input int nx);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (ack_ff[i] !== 1'b1 && n < 400);
    check(ack_ff[i], 1'b1);
    if (nx > 0) check(n, nx + 1);
    @(posedge ref_clk);
    req[i] <= 1'b0;
  endtask : wack
  task automatic acc(input int i, input logic w, input logic [23:0] a,
    input logic [15:0] dv, input logic [17:0] m, input logic [17:0] x,
    input int nx);
    @(posedge ref_clk);
    go(i, w, a, dv, m, x);
    wack(i, nx);
  endtask : acc
  // ==========
  // Monitor: pops the oldest note on every acknowledge
  always @(posedge ref_clk) begin
    #1;
    cyc++;
    if (ack_ff !== 4'h0) begin
      t = q.pop_front();
      check(rdata_ff & t[35:18], t[17:0]);
    end
    if (single_err_irq_ff) se++;
    if (mem_err_irq_ff) me++;
    if (wp_viol_irq_ff) wp++;
    if (host_memory_error_ff) hm++;
    if (cyc == 6000) begin
      errors++;
      print_verdict();
    end
  end
  // ==========
  // Scenarios
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    d = $random(seed);
    e = $random(seed);
    k = {$random(seed)} % 16;
    acc(3, 1, ELOG_ADDR, 16'h0002, 18'h0, 18'h0, 1);
    acc(0, 1, W1, d, 18'h0, 18'h0, WR_CYC);
    acc(0, 0, W1, 16'h0, ALL, {2'b00, d}, RD_CYC);
    @(posedge ref_clk);
    go(0, 1'b0, W1, 16'h0, ALL, {2'b00, d});
    go(3, 1'b0, 24'h000100, 16'h0, ALL, {2'b00, d});
    wack(0, RD_CYC);
    wack(3, 0);
    acc(0, 0, ROM_BASE, 16'h0, ALL, 18'h0, 1);
    cb_wr_dis <= 1'b1;
    acc(0, 1, W1, d ^ (16'h0001 << k), 18'h0, 18'h0, WR_CYC);
    cb_wr_dis <= 1'b0;
    acc(3, 0, 24'h000100, 16'h0, ALL, {2'b00, d}, RD_CYC);
    check(se, 1);
    check(me, 1);
    acc(0, 1, W2, e, 18'h0, 18'h0, WR_CYC);
    cb_wr_dis <= 1'b1;
    acc(0, 1, W2, e ^ 16'h0003, 18'h0, 18'h0, WR_CYC);
    cb_wr_dis <= 1'b0;
    acc(0, 0, W2, 16'h0, 18'h30000, 18'h30000, RD_CYC);
    check(hm, 1);
    check(me, 2);
    acc(3, 0, EADDR_ADDR, 16'h0, ALL, 18'h00080, 1);
    acc(3, 0, SYND_ADDR, 16'h0, ALL, {10'h0, WHO_CPU, SYN_CODE[k]}, 1);
    acc(0, 0, W2, 16'h0, 18'h30000, 18'h30000, RD_CYC);
    acc(3, 0, SYND_ADDR, 16'h0, 18'h000c0, {10'h0, WHO_HOST, 6'h00}, 1);
    acc(3, 0, EADDR_ADDR, 16'h0, ALL, 18'h00100, 1);
    // Upper RAM half only for DMA; output DMA writes are never blocked
    acc(2, 0, W1, 16'h0, ALL, 18'h0, 1);
    acc(1, 1, 24'hff0010, e, 18'h0, 18'h0, DMA_CYC);
    acc(3, 0, 24'h010010, 16'h0, ALL, {2'b00, e}, RD_CYC);
    cpu_user <= 1'b1;
    @(posedge ref_clk);
    go(3, 1'b1, 24'h000400, d, 18'h0, 18'h0);
    void'(q.pop_back());
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (cpu_bus_err_ff !== 1'b1 && n < 400);
    check(n, BUS_TO_CYC + 1);
    @(posedge ref_clk);
    req[3] <= 1'b0;
    check(wp, 1);
    acc(3, 1, PT_BASE + 24'h400, 16'h0001, 18'h0, 18'h0, 1);
    cpu_user <= 1'b0;
    acc(3, 0, PT_BASE + 24'h400, 16'h0, 18'h1, 18'h0, 1);
    acc(3, 1, PT_BASE + 24'h400, 16'h0001, 18'h0, 18'h0, 1);
    cpu_user <= 1'b1;
    acc(3, 1, 24'h000400, d, 18'h0, 18'h0, WR_CYC);
    acc(3, 0, 24'h000400, 16'h0, ALL, {2'b00, d}, RD_CYC);
    master_clear <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (power_low_irq_ff !== 1'b1 && n < 20);
    check(power_low_irq_ff, 1'b1);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (local_reset_ff !== 1'b1 && n < 100);
    check(n, MC);
    print_verdict();
  end
endmodule : tb_edac_memory_protect_ctrl

// ### rtl/ecc_if.sv
/*
  Carrier between the controller and its error corrector.
  Assumes both ends sit on the same clock; all signals are combinational.
*/
`timescale 1ns/1ps
interface ecc_if;
  logic [15:0] wr_data;
  logic [5:0] wr_check;
  logic [15:0] rd_data;
  logic [5:0] rd_check;
  logic [15:0] fixed;
  logic [5:0] syndrome;
  logic single;
  logic double;
  modport coder (input wr_data, rd_data, rd_check,
                 output wr_check, fixed, syndrome, single, double);
  modport user (output wr_data, rd_data, rd_check,
                input wr_check, fixed, syndrome, single, double);
endinterface : ecc_if

// ### rtl/edac_coder.sv
/*
  Check-bit generator and single-error corrector for the 22-bit RAM word.
  Assumes the caller presents write data and raw read word combinationally.
*/
`timescale 1ns/1ps
module edac_coder (
  ecc_if.coder bus
);
  import edac_pkg::*;

  logic [5:0] h;
  logic hit;

  function automatic logic [5:0] chk_gen(input logic [15:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < 16; i++) begin
      if (d[i]) begin
        c = c ^ ~SYN_CODE[i];
      end
    end
    return c;
  endfunction : chk_gen

  // ===========================================================
  // Encode and correct
  always_comb begin
    bus.wr_check = chk_gen(bus.wr_data);
    h = chk_gen(bus.rd_data) ^ bus.rd_check;
    bus.syndrome = ~h; // see [R12]
    bus.fixed = bus.rd_data;
    hit = 1'b0;
    for (int i = 0; i < 22; i++) begin
      if (SYN_CODE[i] == ~h) begin
        hit = 1'b1;
        // Only the returned copy is flipped, RAM keeps the bad bit
        if (i < 16) begin
          bus.fixed[i] = ~bus.rd_data[i]; // see [R6]
        end
      end
    end
    // Odd weight that matches no column cannot be fixed safely
    bus.single = (^h) & hit;
    bus.double = (h != 6'h00) & ~((^h) & hit);
  end
endmodule : edac_coder

// ### rtl/edac_memory_protect_ctrl.sv
/*
  Local memory controller: arbitration, wait states, error correction and
  logging, write protection and delayed local reset on master clear.
  Assumes requesters hold req until their ack pulse, and a RAM that
  returns the addressed word on ram_rdata while ram_cs_ff is high.
*/
`timescale 1ns/1ps
module edac_memory_protect_ctrl #(
  parameter int MCLR_CYC = edac_pkg::MCLR_DELAY_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] req,
  input wire logic [3:0] we,
  input wire logic [3:0][edac_pkg::AW-1:0] addr,
  input wire logic [3:0][15:0] wdata,
  input wire logic cpu_user,
  input wire logic cb_wr_dis,
  input wire logic master_clear,
  input wire logic [21:0] ram_rdata,
  input wire logic [15:0] rom_rdata,
  output logic [3:0] ack_ff,
  output logic [17:0] rdata_ff,
  output logic cpu_bus_err_ff,
  output logic host_memory_error_ff,
  output logic ram_cs_ff,
  output logic ram_we_data_ff,
  output logic ram_we_check_ff,
  output logic [15:0] ram_addr_ff,
  output logic [21:0] ram_wdata_ff,
  output logic [11:0] rom_addr_ff,
  output logic single_err_irq_ff,
  output logic mem_err_irq_ff,
  output logic wp_viol_irq_ff,
  output logic power_low_irq_ff,
  output logic local_reset_ff
);
  import edac_pkg::*;

  ecc_if eb ();
  mem_state_e state_ff;
  logic [7:0] cnt_ff;
  acc_kind_e kind_ff;
  logic [1:0] who_ff;
  logic cwe_ff;
  logic [AW-1:0] caddr_ff;
  logic [15:0] cwd_ff;
  logic prot_ff [0:PT_SEGS-1];
  logic elog_en_ff;
  logic lock_ff;
  logic [7:0] syn_ff;
  logic [15:0] eaddr_ff;
  logic mc_s1_ff, mc_s2_ff, mc_s3_ff, mc_lvl_ff;
  logic mcd_run_ff;
  logic [15:0] mcd_cnt_ff;
  logic [3:0] grant;
  logic [1:0] gi;
  logic [AW-1:0] g_addr;
  logic g_we;
  logic [15:0] g_wd;
  acc_kind_e g_kind;
  logic start, done, err_ev, take, syn_rd, mc_rise;
  logic [17:0] rd_mux;

  // ===========================================================
  // Decode helpers
  function automatic acc_kind_e decode(input logic [1:0] who,
      input logic [AW-1:0] a, input logic w, input logic u,
      input logic p);
    logic img, ram;
    img = a >= RAM_IMG_BASE;
    ram = img || (who == REQ_CPU && a < RAM_LOW_TOP);
    if (who != REQ_CPU && !img) begin
      ram = 1'b0; // see [R4]
    end
    if ((who == REQ_ODMA || who == REQ_IDMA) && !a[16]) begin
      ram = 1'b0; // see [R5]
    end
    decode = K_NONE;
    if (ram) begin
      // Host, output DMA and supervisor writes bypass the table
      if (w && !p && (who == REQ_IDMA || (who == REQ_CPU && u))) begin
        decode = K_VIOL; // see [R15]
      end else begin
        decode = K_RAM;
      end
    end else if (who == REQ_CPU) begin
      if (a >= ROM_BASE && a < ROM_TOP && !w) begin
        decode = K_ROM; // see [R2]
      end else if (a >= PT_BASE && a < PT_TOP) begin
        decode = u ? K_NONE : K_PT; // see [R17]
      end else if (a == SYND_ADDR || a == EADDR_ADDR || a == ELOG_ADDR) begin
        decode = K_REG;
      end
    end
  endfunction : decode

  function automatic logic [7:0] cycles(input acc_kind_e k,
      input logic w, input logic [1:0] who);
    cycles = 8'h01;
    if (k == K_RAM) begin
      if (who == REQ_ODMA || who == REQ_IDMA) begin
        cycles = 8'(DMA_CYC); // see [R5]
      end else begin
        cycles = w ? 8'(WR_CYC) : 8'(RD_CYC); // see [R1]
      end
    end else if (k == K_VIOL) begin
      cycles = (who == REQ_CPU) ? 8'(BUS_TO_CYC) : 8'(WR_CYC);
    end
  endfunction : cycles

  function automatic logic [1:0] who_code(input logic [1:0] who);
    case (who)
      REQ_HOST: who_code = WHO_HOST;
      REQ_CPU: who_code = WHO_CPU;
      default: who_code = WHO_DMA;
    endcase
  endfunction : who_code

  // ===========================================================
  // Arbitration and request mux
  mem_arbiter u_arb (
    .req(req),
    .free(state_ff == ST_IDLE),
    .grant(grant)
  );

  always_comb begin
    gi = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (grant[i]) begin
        gi = 2'(i);
      end
    end
    g_addr = addr[gi];
    g_we = we[gi];
    g_wd = wdata[gi];
    g_kind = decode(gi, g_addr, g_we, cpu_user, prot_ff[g_addr[16:7]]);
  end

  assign start = (state_ff == ST_IDLE) && (grant != 4'h0);
  assign done = (state_ff == ST_RUN) && (cnt_ff == 8'h00);

  // ===========================================================
  // Error corrector
  assign eb.wr_data = g_wd;
  assign eb.rd_data = ram_rdata[15:0];
  assign eb.rd_check = ram_rdata[21:16];

  edac_coder u_coder (
    .bus(eb)
  );

  // ===========================================================
  // Memory cycle sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            state_ff <= ST_RUN;
            cnt_ff <= cycles(g_kind, g_we, gi) - 8'h01;
          end
        end
        ST_RUN: begin
          if (cnt_ff == 8'h00) begin
            state_ff <= ST_GAP; // see [R22]
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        // Lets the served requester drop req before the next grant
        ST_GAP: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      kind_ff <= K_NONE;
      who_ff <= 2'h0;
      cwe_ff <= 1'b0;
      caddr_ff <= '0;
      cwd_ff <= 16'h0000;
    end else if (start) begin
      kind_ff <= g_kind;
      who_ff <= gi;
      cwe_ff <= g_we;
      caddr_ff <= g_addr;
      cwd_ff <= g_wd;
    end
  end

  // ===========================================================
  // RAM and ROM drive
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ram_cs_ff <= 1'b0;
      ram_we_data_ff <= 1'b0;
      ram_we_check_ff <= 1'b0;
      ram_addr_ff <= 16'h0000;
      ram_wdata_ff <= 22'h000000;
    end else if (start && g_kind == K_RAM) begin
      ram_cs_ff <= 1'b1;
      ram_addr_ff <= g_addr[16:1];
      ram_we_data_ff <= g_we;
      ram_we_check_ff <= g_we && !cb_wr_dis; // see [R13]
      ram_wdata_ff <= {eb.wr_check, g_wd};
    end else if (done) begin
      ram_cs_ff <= 1'b0;
      ram_we_data_ff <= 1'b0;
      ram_we_check_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rom_addr_ff <= 12'h000;
    end else if (start && g_kind == K_ROM) begin
      rom_addr_ff <= g_addr[12:1];
    end
  end

  // ===========================================================
  // Read data and answers
  always_comb begin
    rd_mux = 18'h00000;
    case (kind_ff)
      K_RAM: begin
        if (!cwe_ff) begin
          rd_mux[15:0] = eb.fixed; // see [R6]
          if (who_ff == REQ_HOST && eb.double) begin
            rd_mux[17:16] = 2'b11; // see [R10]
          end
        end
      end
      K_ROM: rd_mux[15:0] = rom_rdata;
      K_REG: begin
        if (caddr_ff == SYND_ADDR) begin
          rd_mux[7:0] = syn_ff;
        end else if (caddr_ff == EADDR_ADDR) begin
          rd_mux[15:0] = eaddr_ff; // see [R23]
        end else begin
          rd_mux[ELOG_EN_BIT] = elog_en_ff;
        end
      end
      K_PT: rd_mux[0] = prot_ff[caddr_ff[16:7]];
      default: rd_mux = 18'h00000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_ff <= 4'h0;
      rdata_ff <= 18'h00000;
      cpu_bus_err_ff <= 1'b0;
      host_memory_error_ff <= 1'b0;
    end else begin
      ack_ff <= 4'h0;
      cpu_bus_err_ff <= 1'b0;
      host_memory_error_ff <= 1'b0;
      if (done) begin
        rdata_ff <= rd_mux;
        if (kind_ff == K_VIOL && who_ff == REQ_CPU) begin
          cpu_bus_err_ff <= 1'b1; // see [R16]
        end else begin
          ack_ff[who_ff] <= 1'b1;
        end
        if (err_ev && who_ff == REQ_HOST && eb.double) begin
          host_memory_error_ff <= 1'b1; // see [R10]
        end
      end
    end
  end

  // ===========================================================
  // Protect table and error log select
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < PT_SEGS; i++) begin
        prot_ff[i] <= PT_RESET;
      end
    end else if (done && kind_ff == K_PT && cwe_ff) begin
      prot_ff[caddr_ff[16:7]] <= (cwd_ff[2:0] == PT_ALLOW); // see [R14]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      elog_en_ff <= 1'b0;
    end else if (done && kind_ff == K_REG && cwe_ff
                 && caddr_ff == ELOG_ADDR) begin
      elog_en_ff <= cwd_ff[ELOG_EN_BIT]; // see [R21]
    end
  end

  // ===========================================================
  // Error capture and interrupts
  assign err_ev = done && kind_ff == K_RAM && !cwe_ff;
  assign take = err_ev && (eb.double || (eb.single && elog_en_ff));
  assign syn_rd = done && kind_ff == K_REG && !cwe_ff
                  && caddr_ff == SYND_ADDR;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lock_ff <= 1'b0;
      syn_ff <= {2'b00, SYN_NONE};
      eaddr_ff <= 16'h0000;
    end else begin
      if (syn_rd) begin
        lock_ff <= 1'b0; // see [R9]
      end
      // A new error in the same cycle as a release is not captured; lock_ff must already be clear
      if (take && !lock_ff) begin
        lock_ff <= 1'b1;
        syn_ff <= {who_code(who_ff), eb.syndrome}; // see [R11] see [R7] see [R8]
        eaddr_ff <= caddr_ff[16:1];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      single_err_irq_ff <= 1'b0;
      mem_err_irq_ff <= 1'b0;
      wp_viol_irq_ff <= 1'b0;
    end else begin
      single_err_irq_ff <= err_ev && eb.single; // see [R19]
      mem_err_irq_ff <= take; // see [R20]
      wp_viol_irq_ff <= done && kind_ff == K_VIOL; // see [R16]
    end
  end

  // ===========================================================
  // Master clear and delayed local reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mc_s1_ff <= 1'b0;
      mc_s2_ff <= 1'b0;
      mc_s3_ff <= 1'b0;
      mc_lvl_ff <= 1'b0;
    end else begin
      mc_s1_ff <= master_clear;
      mc_s2_ff <= mc_s1_ff;
      mc_s3_ff <= mc_s2_ff;
      if (mc_s2_ff == mc_s3_ff) begin
        mc_lvl_ff <= mc_s3_ff;
      end
    end
  end

  assign mc_rise = (mc_s2_ff == mc_s3_ff) && mc_s3_ff && !mc_lvl_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      power_low_irq_ff <= 1'b0;
      mcd_run_ff <= 1'b0;
      mcd_cnt_ff <= 16'h0000;
      local_reset_ff <= 1'b0;
    end else begin
      power_low_irq_ff <= mc_rise; // see [R18]
      if (mc_rise) begin
        mcd_run_ff <= 1'b1;
        mcd_cnt_ff <= 16'h0000;
      end else if (mcd_run_ff) begin
        mcd_cnt_ff <= mcd_cnt_ff + 16'h0001;
        if (mcd_cnt_ff == 16'(MCLR_CYC - 1)) begin
          local_reset_ff <= 1'b1; // see [R18]
          mcd_run_ff <= 1'b0;
        end
      end else if (!mc_lvl_ff) begin
        local_reset_ff <= 1'b0;
      end
    end
  end

  // ===========================================================
  // Checks
  a_read_wait_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
    start && g_kind == K_RAM && !g_we && (gi == REQ_HOST || gi == REQ_CPU)
    |-> ##1 (ack_ff == 4'h0)[*8] ##6 (ack_ff != 4'h0)) // see [R1]
    else $error("read cycle length wrong");

  a_write_wait_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
    start && g_kind == K_RAM && g_we && (gi == REQ_HOST || gi == REQ_CPU)
    |-> ##27 (ack_ff != 4'h0)) // see [R1]
    else $error("write cycle length wrong");

  a_dma_hold_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
    start && g_kind == K_RAM && (gi == REQ_ODMA || gi == REQ_IDMA)
    |-> ##161 (ack_ff != 4'h0)) // see [R5]
    else $error("dma hold length wrong");

  a_arb_prio_pick: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_ff == ST_IDLE && req[0] |-> grant == 4'h1) // see [R3]
    else $error("host not first");

  a_one_grant_cycle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_ff != ST_IDLE |-> grant == 4'h0) // see [R22]
    else $error("grant during busy cycle");

  a_viol_no_ram: assert property (@(posedge ref_clk) disable iff (sys_rst)
    start && g_kind == K_VIOL |=> !ram_cs_ff && !ram_we_data_ff) // see [R15]
    else $error("protected write reached ram");

  a_bus_err_irq: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cpu_bus_err_ff |-> wp_viol_irq_ff && ack_ff == 4'h0) // see [R16]
    else $error("bus error without violation irq");

  a_cb_keep_old: assert property (@(posedge ref_clk) disable iff (sys_rst)
    start && g_kind == K_RAM && g_we && cb_wr_dis
    |=> ram_we_data_ff && !ram_we_check_ff) // see [R13]
    else $error("check bits written while disabled");

  a_lock_holds_syn: assert property (@(posedge ref_clk) disable iff (sys_rst)
    lock_ff && !syn_rd |=> $stable(syn_ff) && $stable(eaddr_ff)) // see [R9]
    else $error("capture overwritten while locked");

  a_single_no_log: assert property (@(posedge ref_clk) disable iff (sys_rst)
    err_ev && eb.single && !elog_en_ff
    |=> single_err_irq_ff && !mem_err_irq_ff) // see [R19]
    else $error("single error irq routing wrong");

  a_host_host_memory_error_bits: assert property (@(posedge ref_clk) disable iff (sys_rst)
    host_memory_error_ff |-> ack_ff[0] && rdata_ff[17:16] == 2'b11) // see [R10]
    else $error("host error without parity bits");

  a_reset_after_pl: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(local_reset_ff) |-> $past(mcd_cnt_ff) == 16'(MCLR_CYC - 1)) // see [R18]
    else $error("local reset delay wrong");
endmodule : edac_memory_protect_ctrl

// ### rtl/edac_pkg.sv
/*
  Constants, types and layout for the error-corrected local memory controller.
  Assumes one 100 MHz clock and a 24-bit byte address space on every requester.
*/
// Contract
// [R1] RAM reads take one 125 ns wait state, writes take two.
// [R2] ROM answers only the local processor; RAM answers every requester.
// [R3] Fixed priority: host, output DMA, input DMA, then local processor.
// [R4] Whole RAM is mirrored at 16256K-16384K; host and DMA use that window.
// [R5] A DMA cycle holds the bus 1.6 us and reaches only upper RAM half.
// [R6] Reads return corrected data; the faulty stored word is left alone.
// [R7] With logging on, a single error latches syndrome, address and interrupt.
// [R8] A double error always latches syndrome, address and raises interrupt.
// [R9] No new capture until the local processor reads the syndrome register.
// [R10] Host read double error: host memory error plus data bits 16, 17.
// [R11] Syndrome latch: 6 syndrome bits, bits 7:6 name the requester.
// [R12] Six-bit syndrome selects failing bit 0-21; all ones means clean.
// [R13] Check-bit write disable keeps old check bits on writes.
// [R14] Protect table word at segment+15360K: 001 allows, 0 protects 128 bytes.
// [R15] Only input DMA and user processor writes are checked for protection.
// [R16] Protected write times out, gives bus error and write protect interrupt; input DMA ones are acked after WR_CYC cycles without bus error.
// [R17] Protect table accesses in user state are ignored.
// [R18] Master clear raises power low, local reset follows 50 us later.
// [R19] Single memory error interrupt fires on every corrected single error.
// [R20] Memory error interrupt on every double, on singles only while logging.
// [R21] Software sets bit 1 of error log select to enable logging.
// [R22] One grant per memory cycle; priority re-evaluated after it ends.
// [R23] Error address latch is readable without releasing the capture lock.
package edac_pkg;
  localparam int AW = 24;
  localparam int CLK_NS = 10;
  localparam int WAIT_NS = 125;
  localparam int WAIT_CYC = (WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = 1 * WAIT_CYC;
  localparam int WR_CYC = 2 * WAIT_CYC;
  localparam int DMA_HOLD_NS = 1600;
  localparam int DMA_CYC = (DMA_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUS_TIMEOUT_NS = 2000;
  localparam int BUS_TO_CYC = BUS_TIMEOUT_NS / CLK_NS;
  localparam int MCLR_DELAY_NS = 50000;
  localparam int MCLR_DELAY_CYC = (MCLR_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [AW-1:0] RAM_LOW_TOP = 24'h020000;
  localparam logic [AW-1:0] RAM_IMG_BASE = 24'hfe0000;
  localparam logic [AW-1:0] ROM_BASE = 24'hef8000;
  localparam logic [AW-1:0] ROM_TOP = 24'hefa000;
  localparam logic [AW-1:0] PT_BASE = 24'hf00000;
  localparam logic [AW-1:0] PT_TOP = 24'hf20000;
  localparam logic [AW-1:0] SYND_ADDR = 24'hef0140;
  localparam logic [AW-1:0] EADDR_ADDR = 24'hef0160;
  localparam logic [AW-1:0] ELOG_ADDR = 24'hef01a0;
  localparam int ELOG_EN_BIT = 1;
  localparam int PT_SEGS = 1024;
  localparam logic [2:0] PT_ALLOW = 3'h1;
  localparam logic PT_RESET = 1'b0;
  localparam logic [1:0] REQ_HOST = 2'h0;
  localparam logic [1:0] REQ_ODMA = 2'h1;
  localparam logic [1:0] REQ_IDMA = 2'h2;
  localparam logic [1:0] REQ_CPU = 2'h3;
  localparam logic [1:0] WHO_HOST = 2'h0;
  localparam logic [1:0] WHO_DMA = 2'h2;
  localparam logic [1:0] WHO_CPU = 2'h3;
  localparam logic [5:0] SYN_NONE = 6'h3f;
  localparam logic [5:0] SYN_CODE [0:21] = '{
    6'h34, 6'h32, 6'h31, 6'h2c, 6'h2a, 6'h29, 6'h25, 6'h23,
    6'h1c, 6'h1a, 6'h16, 6'h15, 6'h13, 6'h0e, 6'h0d, 6'h0b,
    6'h3e, 6'h3d, 6'h3b, 6'h37, 6'h2f, 6'h1f};
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_GAP = 2'b10
  } mem_state_e;
  typedef enum logic [2:0] {
    K_NONE = 3'b000,
    K_RAM = 3'b001,
    K_ROM = 3'b010,
    K_REG = 3'b011,
    K_PT = 3'b100,
    K_VIOL = 3'b101
  } acc_kind_e;
endpackage : edac_pkg

// ### rtl/mem_arbiter.sv
/*
  Fixed-priority grant for the shared memory bus.
  Assumes request bit 0 is the most urgent and that free marks an idle bus.
*/
`timescale 1ns/1ps
module mem_arbiter (
  input wire logic [3:0] req,
  input wire logic free,
  output logic [3:0] grant
);
  function automatic logic [3:0] lowest(input logic [3:0] r);
    return r & (~r + 4'h1);
  endfunction : lowest

  // ===========================================================
  // Grant only while no cycle is in flight
  always_comb begin
    grant = free ? lowest(req) : 4'h0; // see [R3] see [R22]
  end
endmodule : mem_arbiter
